// ### bench/ctm_pin_partner.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// far side: count clock pin source and wave pin monitor
module ctm_pin_partner (
    input wire logic pclk,
    output logic external_count_pin,
    input wire logic wave_out_pin_a
);
    int high_cnt = 0;

    // count pin idles low outside bursts
    initial external_count_pin = 1'b0;

    // tally cycles with the wave pin high
    always @(posedge pclk) begin
        if (wave_out_pin_a === 1'b1) begin
            high_cnt <= high_cnt + 1;
        end
    end

    // slow pulses, well below the synchroniser rate
    task automatic pulse(input int n);
        repeat (n) begin
            repeat (3) @(posedge pclk);
            external_count_pin <= 1'b1;
            repeat (3) @(posedge pclk);
            external_count_pin <= 1'b0;
        end
    endtask
endmodule // ctm_pin_partner

`default_nettype wire

// ### bench/tb_ctm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.svh"

// ==========================================
// bench top
module tb_ctm_timer;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ext_pin, pin_a, pin_b, pin_oe, rerr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [3:0] pstrb;
    logic [1:0] act;
    logic ini, inv, e;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] h0;

    // device and far side
    ctm_timer #(.ADDR_W(8)) ctm_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_count_pin(ext_pin), .wave_out_pin_a(pin_a), .wave_out_pin_b(pin_b),
        .wave_out_oe(pin_oe));
    ctm_pin_partner ctm_pin_partner_inst (.pclk(pclk), .external_count_pin(ext_pin), .wave_out_pin_a(pin_a));

    // 200 MHz clock
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // hang guard
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            failures = failures + 1;
            close_out();
        end
    end

    task close_out();
        if (failures == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one apb transfer, held until pready
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    task t_regs();
        rd(`CTM_OFF_CTRL0); chk(rdat, 32'h0);
        rd(`CTM_OFF_CTRL1); chk(rdat, 32'h0);
        rd(8'h20); chk(32'(rerr), 32'h1);
        wr(`CTM_OFF_COUNT, 32'h5);
        rd(`CTM_OFF_COUNT); chk(rdat, 32'h0);
    endtask

    task t_run();
        wr(`CTM_OFF_CTRL0, 32'h10);
        repeat (20) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(rdat, 32'h0);
        wr(`CTM_OFF_CTRL0, 32'h18);
        repeat (40) @(posedge pclk);
        wr(`CTM_OFF_CTRL0, 32'h10);
        rd(`CTM_OFF_COUNT);
        h0 = rdat;
        repeat (20) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(rdat, h0);
        chk(32'(h0 > 40), 32'h1);
        wr(`CTM_OFF_CTRL0, 32'h18);
        rd(`CTM_OFF_COUNT); chk(32'(rdat < 8), 32'h1);
        wr(`CTM_OFF_CTRL0, 32'h98);
        rd(`CTM_OFF_COUNT);
        h0 = rdat;
        repeat (20) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(rdat, h0);
        wr(`CTM_OFF_CTRL0, 32'h18);
        repeat (20) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(32'(rdat > h0), 32'h1);
    endtask

    task t_ext();
        wr(`CTM_OFF_CTRL0, 32'h60);
        wr(`CTM_OFF_CTRL1, 32'hC0);
        wr(`CTM_OFF_CTRL0, 32'h68);
        ctm_pin_partner_inst.pulse(5);
        repeat (10) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(rdat, 32'h5);
        wr(`CTM_OFF_CTRL0, 32'h70);
        wr(`CTM_OFF_CTRL0, 32'h78);
        ctm_pin_partner_inst.pulse(5);
        repeat (10) @(posedge pclk);
        rd(`CTM_OFF_COUNT); chk(rdat, 32'h5);
    endtask

    // stop, pick a clock, run a fixed span, then judge the tick count
    task t_clk(input logic [2:0] ck, input logic [31:0] lo, input logic [31:0] hi);
        wr(`CTM_OFF_CTRL0, {25'h0, ck, 4'h0});
        wr(`CTM_OFF_CTRL1, 32'hC0);
        wr(`CTM_OFF_CTRL0, {25'h0, ck, 4'h8});
        repeat (1024) @(posedge pclk);
        wr(`CTM_OFF_CTRL0, {25'h0, ck, 4'h0});
        rd(`CTM_OFF_COUNT); chk(32'(rdat >= lo && rdat <= hi), 32'h1);
    endtask

    // stop, set up, restart, then judge the flags
    task t_flag(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a, input logic [31:0] ex);
        wr(`CTM_OFF_CTRL0, {28'h1, 1'b0, p});
        wr(`CTM_OFF_CTRL1, {24'h0, c1});
        wr(`CTM_OFF_CMPA, {22'h0, a});
        wr(`CTM_OFF_FLAGS, 32'h3);
        wr(`CTM_OFF_CTRL0, {28'h1, 1'b1, p});
        repeat (1100) @(posedge pclk);
        rd(`CTM_OFF_FLAGS); chk(rdat, ex);
        @(negedge pclk);
        chk(32'(pin_oe), 32'(!c1[6]));
    endtask

    // stop, set up, restart, then count wave pin high cycles
    task t_pwm(input logic [7:0] c1, input logic [2:0] p, input logic [9:0] a, input int win, input int ex);
        wr(`CTM_OFF_CTRL0, {28'h1, 1'b0, p});
        wr(`CTM_OFF_CTRL1, {24'h0, c1});
        wr(`CTM_OFF_CMPA, {22'h0, a});
        wr(`CTM_OFF_CTRL0, {28'h1, 1'b1, p});
        repeat (20) @(negedge pclk);
        h0 = ctm_pin_partner_inst.high_cnt;
        repeat (win) @(negedge pclk);
        chk(32'(ctm_pin_partner_inst.high_cnt - h0), 32'(ex));
    endtask

    task t_cmp();
        for (int k = 0; k < 16; k++) begin
            act = 2'(k >> 2);
            ini = k[1];
            inv = k[0];
            e = (act == 2'd0) ? ini : (act == 2'd1) ? 1'b0 : (act == 2'd2) ? 1'b1 : ~ini;
            wr(`CTM_OFF_CTRL0, 32'h10);
            wr(`CTM_OFF_CTRL1, {24'h0, 2'b00, act, ini, inv, 2'b00});
            wr(`CTM_OFF_CMPA, 32'd20);
            wr(`CTM_OFF_CTRL0, 32'h18);
            repeat (4) @(negedge pclk);
            chk(32'(pin_a), 32'(ini ^ inv));
            repeat (40) @(negedge pclk);
            chk(32'(pin_a), 32'(e ^ inv));
            chk(32'(pin_b), 32'(e ^ inv));
        end
    endtask

    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        pstrb = 4'hF;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_run();
        t_ext();
        t_clk(3'd0, 32'd256, 32'd257);
        t_clk(3'd2, 32'd64, 32'd65);
        t_clk(3'd3, 32'd16, 32'd17);
        t_clk(3'd4, 32'd4, 32'd5);
        t_clk(3'd5, 32'd0, 32'd0);
        t_flag(8'h00, 3'd1, 10'd50, 32'h3);
        t_flag(8'h40, 3'd1, 10'd50, 32'h3);
        t_flag(8'h01, 3'd1, 10'd200, 32'h1);
        t_flag(8'h01, 3'd0, 10'd0, 32'h0);
        t_flag(8'h00, 3'd0, 10'd0, 32'h2);
        t_flag(8'hC0, 3'd1, 10'd50, 32'h3);
        t_flag(8'h81, 3'd1, 10'd50, 32'h3);
        t_cmp();
        for (int p = 0; p < 8; p++) begin
            t_pwm(8'hA8, 3'(p), 10'd64, (p == 0) ? 2048 : 256 * p, 128);
        end
        t_pwm(8'hA8, 3'd1, 10'd200, 256, 256);
        t_pwm(8'h88, 3'd1, 10'd32, 256, 0);
        t_pwm(8'h98, 3'd1, 10'd32, 256, 256);
        t_pwm(8'hB8, 3'd1, 10'd32, 256, 0);
        t_pwm(8'hA0, 3'd1, 10'd32, 256, 192);
        t_pwm(8'hAC, 3'd1, 10'd32, 256, 192);
        t_pwm(8'hAA, 3'd1, 10'd256, 512, 256);
        close_out();
    end
endmodule // tb_ctm_timer

`default_nettype wire

// ### design/ctm_consts.svh
`ifndef CTM_CONSTS_SVH
`define CTM_CONSTS_SVH

// ==========================================
// register byte offsets on the apb window
`define CTM_OFF_CTRL0 8'h00
`define CTM_OFF_CTRL1 8'h04
`define CTM_OFF_COUNT 8'h08
`define CTM_OFF_CMPA 8'h0C
`define CTM_OFF_FLAGS 8'h10

// ==========================================
// reset values
`define CTM_RST_CTRL0 8'h00
`define CTM_RST_CTRL1 8'h00
`define CTM_RST_CMPA 10'h000

// ==========================================
// flag register bit positions
`define CTM_FLAG_A_BIT 0
`define CTM_FLAG_P_BIT 1

// ==========================================
// counter geometry and prescaler taps
`define CTM_CNT_FULL 11'h400
`define CTM_CNT_MAX 10'h3FF
`define CTM_PRE_W 8
`define CTM_TAP_DIV4 2
`define CTM_TAP_DIV16 4
`define CTM_TAP_DIV64 6
`define CTM_TAP_LIRC 8

`endif

// ### design/ctm_pkg.sv
`default_nettype none

package ctm_pkg;

    // ==========================================
    // control register layouts
    typedef struct packed {
        logic count_hold;
        logic [2:0] count_clock_select;
        logic timer_run;
        logic [2:0] period_code;
    } ctm_ctrl0_s;

    typedef struct packed {
        logic [1:0] mode_field;
        logic [1:0] pin_action_field;
        logic output_initial_level;
        logic output_invert;
        logic period_duty_swap;
        logic clear_source_select;
    } ctm_ctrl1_s;

    // ==========================================
    // operating modes
    typedef enum logic [1:0] {
        CTM_MODE_CMP = 2'b00,
        CTM_MODE_UNDEF = 2'b01,
        CTM_MODE_PWM = 2'b10,
        CTM_MODE_TC = 2'b11
    } ctm_mode_e;

    // ==========================================
    // counting clock sources
    typedef enum logic [2:0] {
        CTM_CK_SYS4 = 3'b000,
        CTM_CK_SYS = 3'b001,
        CTM_CK_H16 = 3'b010,
        CTM_CK_H64 = 3'b011,
        CTM_CK_LIRC = 3'b100,
        CTM_CK_UNDEF = 3'b101,
        CTM_CK_EXT_RISE = 3'b110,
        CTM_CK_EXT_FALL = 3'b111
    } ctm_clk_e;

endpackage

`default_nettype wire

// ### design/ctm_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "ctm_consts.svh"

module ctm_timer
    import ctm_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_count_pin,
    output logic wave_out_pin_a,
    output logic wave_out_pin_b,
    output logic wave_out_oe
);

    // ==========================================
    // state
    ctm_ctrl0_s ctrl0_q;
    ctm_ctrl1_s ctrl1_q;
    logic [9:0] cmpa_q;
    logic match_a_flag_q;
    logic match_p_flag_q;
    logic [9:0] cnt_q;
    logic run_d1_q;
    logic [`CTM_PRE_W-1:0] pre_q;
    logic ext_s1_q;
    logic ext_s2_q;
    logic ext_s3_q;
    logic wave_q;
    logic [31:0] prdata_q;

    // ==========================================
    // decode helpers
    ctm_mode_e mode;
    logic is_pwm;
    logic is_cmp;
    logic setup_ph;
    logic wr_acc;
    logic mapped;
    logic [7:0] offs;

    assign mode = ctm_mode_e'(ctrl1_q.mode_field);
    assign is_pwm = (mode == CTM_MODE_PWM);
    assign is_cmp = (mode == CTM_MODE_CMP);
    assign offs = paddr[7:0];
    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;
    assign mapped = (offs == `CTM_OFF_CTRL0) || (offs == `CTM_OFF_CTRL1) || (offs == `CTM_OFF_COUNT)
                    || (offs == `CTM_OFF_CMPA) || (offs == `CTM_OFF_FLAGS);

    // ==========================================
    // apb answer: zero wait, error on unmapped
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_q;

    // read data captured in setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_ph && !pwrite) begin
            case (offs)
                `CTM_OFF_CTRL0: prdata_q <= {24'h00_0000, ctrl0_q};
                `CTM_OFF_CTRL1: prdata_q <= {24'h00_0000, ctrl1_q};
                `CTM_OFF_COUNT: prdata_q <= {22'h0, cnt_q};
                `CTM_OFF_CMPA: prdata_q <= {22'h0, cmpa_q};
                `CTM_OFF_FLAGS: prdata_q <= {30'h0, match_p_flag_q, match_a_flag_q};
                default: prdata_q <= 32'h0000_0000;
            endcase
        end
    end

    // control and compare registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_q <= `CTM_RST_CTRL0;
            ctrl1_q <= `CTM_RST_CTRL1;
            cmpa_q <= `CTM_RST_CMPA;
        end else if (wr_acc) begin
            if (offs == `CTM_OFF_CTRL0 && pstrb[0]) begin
                ctrl0_q <= pwdata[7:0];
            end
            if (offs == `CTM_OFF_CTRL1 && pstrb[0]) begin
                ctrl1_q <= pwdata[7:0];
            end
            if (offs == `CTM_OFF_CMPA) begin
                if (pstrb[0]) begin
                    cmpa_q[7:0] <= pwdata[7:0];
                end
                if (pstrb[1]) begin
                    cmpa_q[9:8] <= pwdata[9:8];
                end
            end
        end
    end

    // ==========================================
    // counting clock selection
    logic run_rise;
    logic ext_rise;
    logic ext_fall;
    logic tick;

    // edges are taken after two flops, so the count pin may be fully asynchronous
    assign run_rise = ctrl0_q.timer_run && !run_d1_q;
    assign ext_rise = ext_s2_q && !ext_s3_q;
    assign ext_fall = !ext_s2_q && ext_s3_q;

    // free-running prescaler and pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            run_d1_q <= 1'b0;
        end else begin
            pre_q <= pre_q + 1'b1;
            ext_s1_q <= external_count_pin;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            run_d1_q <= ctrl0_q.timer_run;
        end
    end

    // one-cycle tick from the chosen source
    always_comb begin
        case (ctm_clk_e'(ctrl0_q.count_clock_select))
            CTM_CK_SYS4: tick = &pre_q[`CTM_TAP_DIV4-1:0];
            CTM_CK_SYS: tick = 1'b1;
            CTM_CK_H16: tick = &pre_q[`CTM_TAP_DIV16-1:0];
            CTM_CK_H64: tick = &pre_q[`CTM_TAP_DIV64-1:0];
            CTM_CK_LIRC: tick = &pre_q[`CTM_TAP_LIRC-1:0];
            CTM_CK_EXT_RISE: tick = ext_rise;
            CTM_CK_EXT_FALL: tick = ext_fall;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================
    // comparators
    logic cnt_en;
    logic [10:0] cnt_nx;
    logic [10:0] pval;
    logic [10:0] aval;
    logic p_hit;
    logic a_hit;
    logic ovf;
    logic clr;
    logic a_set;
    logic p_set;

    // the clearing edge itself never counts, so a fresh run starts from zero
    assign cnt_en = ctrl0_q.timer_run && !run_rise && !ctrl0_q.count_hold && tick;
    assign cnt_nx = {1'b0, cnt_q} + 11'h001;
    assign pval = (ctrl0_q.period_code == 3'h0) ? `CTM_CNT_FULL : {1'b0, ctrl0_q.period_code, 7'h00};
    // a zero compare value never matches, which leaves a free overflow at 3FF
    assign aval = {1'b0, cmpa_q};
    assign p_hit = cnt_en && (cnt_nx == pval);
    assign a_hit = cnt_en && (cmpa_q != 10'h000) && (cnt_nx == aval);
    assign ovf = cnt_en && cnt_nx[10];

    // clear source by mode and selection
    always_comb begin
        if (is_pwm) begin
            clr = ctrl1_q.period_duty_swap ? (a_hit || ovf) : p_hit;
        end else if (ctrl1_q.clear_source_select) begin
            clr = a_hit || ovf;
        end else begin
            clr = p_hit;
        end
    end

    assign a_set = a_hit;
    assign p_set = p_hit && (is_pwm || !ctrl1_q.clear_source_select);

    // ==========================================
    // counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 10'h000;
        end else if (run_rise) begin
            cnt_q <= 10'h000;
        end else if (cnt_en) begin
            cnt_q <= clr ? 10'h000 : cnt_nx[9:0];
        end
    end

    // sticky flags, write one to clear, set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_a_flag_q <= 1'b0;
            match_p_flag_q <= 1'b0;
        end else begin
            if (a_set) begin
                match_a_flag_q <= 1'b1;
            end else if (wr_acc && offs == `CTM_OFF_FLAGS && pstrb[0] && pwdata[`CTM_FLAG_A_BIT]) begin
                match_a_flag_q <= 1'b0;
            end
            if (p_set) begin
                match_p_flag_q <= 1'b1;
            end else if (wr_acc && offs == `CTM_OFF_FLAGS && pstrb[0] && pwdata[`CTM_FLAG_P_BIT]) begin
                match_p_flag_q <= 1'b0;
            end
        end
    end

    // ==========================================
    // pwm level
    logic [10:0] period_v;
    logic [10:0] duty_v;
    logic pwm_active;
    logic oc;

    // duty at or past the period keeps the level active for the whole cycle
    assign oc = ctrl1_q.output_initial_level;
    assign period_v = ctrl1_q.period_duty_swap ? ((cmpa_q == 10'h000) ? `CTM_CNT_FULL : aval) : pval;
    assign duty_v = ctrl1_q.period_duty_swap ? pval : aval;
    assign pwm_active = (duty_v >= period_v) || ({1'b0, cnt_q} < duty_v);

    // waveform state before inversion
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_q <= 1'b0;
        end else if (is_cmp) begin
            if (run_rise) begin
                wave_q <= oc;
            end else if (a_set) begin
                case (ctrl1_q.pin_action_field)
                    2'b01: wave_q <= 1'b0;
                    2'b10: wave_q <= 1'b1;
                    2'b11: wave_q <= !wave_q;
                    default: wave_q <= wave_q;
                endcase
            end
        end else if (is_pwm) begin
            case (ctrl1_q.pin_action_field)
                2'b01: wave_q <= oc;
                2'b10: wave_q <= pwm_active ? oc : !oc;
                default: wave_q <= !oc;
            endcase
        end
    end

    // pin drivers, released in timer/counter and undefined modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wave_out_pin_a <= 1'b0;
            wave_out_pin_b <= 1'b0;
            wave_out_oe <= 1'b0;
        end else begin
            wave_out_pin_a <= (is_cmp || is_pwm) && (wave_q ^ ctrl1_q.output_invert);
            wave_out_pin_b <= (is_cmp || is_pwm) && (wave_q ^ ctrl1_q.output_invert);
            wave_out_oe <= is_cmp || is_pwm;
        end
    end

    // ==========================================
    // assertions
    AST_RUN_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        run_rise |=> (cnt_q == 10'h000)) else $error("counter not cleared on run rising");

    AST_RUN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        !ctrl0_q.timer_run |=> (cnt_q == $past(cnt_q))) else $error("counter moved while off");

    AST_INIT_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
        (run_rise && is_cmp) |=> ##1 (wave_out_pin_a == ($past(oc, 2) ^ $past(ctrl1_q.output_invert, 2))))
        else $error("pin not back at initial level");

    AST_NO_P_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl1_q.clear_source_select && !is_pwm && !match_p_flag_q) |=> !match_p_flag_q)
        else $error("p flag raised with select one");

    AST_OVF_3FF: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt_en && !is_pwm && ctrl1_q.clear_source_select && cmpa_q == 10'h000 && cnt_q == `CTM_CNT_MAX)
        |-> !a_set ##1 (cnt_q == 10'h000)) else $error("no clean overflow at 3FF");

    AST_P_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (p_hit && !is_pwm && !ctrl1_q.clear_source_select) |=> (cnt_q == 10'h000 && match_p_flag_q))
        else $error("p match did not clear counter and set flag");

    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (ctrl0_q.count_hold && !run_rise) [*2] |-> $stable(cnt_q)) else $error("counter moved while held");

    AST_CMP_PIN: assert property (@(posedge pclk) disable iff (!presetn)
        (is_cmp && !a_set && !run_rise && $stable(ctrl1_q)) |=> $stable(wave_q))
        else $error("compare pin changed without A match");

    AST_FULL_DUTY: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && ctrl1_q.pin_action_field == 2'b10 && duty_v >= period_v) |=> (wave_q == $past(oc)))
        else $error("full duty not held active");

    // run edges and period decode
    AST_RUN_FALL_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(ctrl0_q.timer_run) |=> $stable(cnt_q))
        else $error("counter lost its value when run fell");

    AST_P_DECODE: assert property (@(posedge pclk) disable iff (!presetn)
        cnt_en |-> (p_hit == ((cnt_q[9:7] == ctrl0_q.period_code - 3'h1) && (cnt_q[6:0] == 7'h7F))))
        else $error("period match off its 128-count step");

    // flags and clearing
    AST_A_FLAG: assert property (@(posedge pclk) disable iff (!presetn)
        a_hit |=> match_a_flag_q)
        else $error("A match left its flag low");

    AST_SEL_A_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (a_hit && !is_pwm && ctrl1_q.clear_source_select) |=> (cnt_q == 10'h000 && match_a_flag_q))
        else $error("A match did not clear counter with select one");

    AST_PWM_P_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && !ctrl1_q.period_duty_swap && p_hit) |=> (cnt_q == 10'h000 && match_p_flag_q))
        else $error("pwm period match did not clear and flag");

    AST_SWAP_A_CLEAR: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && ctrl1_q.period_duty_swap && a_hit) |=> (cnt_q == 10'h000 && match_a_flag_q))
        else $error("swapped pwm period not set by compare value");

    // pin release and pwm output shape
    AST_TC_PIN_OFF: assert property (@(posedge pclk) disable iff (!presetn)
        (mode == CTM_MODE_TC) |=> (!wave_out_oe && !wave_out_pin_a && !wave_out_pin_b))
        else $error("pins driven in timer/counter mode");

    AST_PWM_INACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && ctrl1_q.pin_action_field == 2'b00) |=> (wave_q == !$past(oc)))
        else $error("pwm not forced inactive");

    AST_PWM_ACTIVE: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && ctrl1_q.pin_action_field == 2'b01) |=> (wave_q == $past(oc)))
        else $error("pwm not forced active");

    AST_PWM_TAIL: assert property (@(posedge pclk) disable iff (!presetn)
        (is_pwm && ctrl1_q.pin_action_field == 2'b10 && duty_v < period_v && {1'b0, cnt_q} >= duty_v)
        |=> (wave_q == !$past(oc))) else $error("pwm active past the duty value");

endmodule // ctm_timer

`default_nettype wire
